// *** sar_consts.svh ***
// constants for the converter control block
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH

`define SAR_BITS 12
`define SAR_MID_CODE 12'h800
`define WORD_BITS 16
`define LEAD_ZEROS 4
`define CTRL_BITS 8
`define CTRL_RST 8'h00
`define CTRL_REF_POS 5
`define CTRL_DUAL_POS 4
`define CTRL_CH_POS 3
`define CTRL_PMH_POS 1
`define CTRL_PML_POS 0
`define PM_CS_SHUTDOWN 2'h0
`define PM_ALWAYS_ON 2'h1
`define PM_AUTO_SHUTDOWN 2'h2
`define PM_AUTO_STANDBY 2'h3
`define SAMPLE_EDGE 2
`define LAST_DECIDE_EDGE 14
`define PDOWN_EDGE 16
`define FIFO_DEPTH 16
`define INT_REF_MV 2500
`define CLK_PERIOD_PS 4000
`define WAKE_FULL_NS 5000
`define WAKE_STBY_NS 1000
`define WAKE_FULL_CYC ((`WAKE_FULL_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WAKE_STBY_CYC ((`WAKE_STBY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// *** sar_pkg.sv ***
// types shared by the converter control block
`include "sar_consts.svh"

package sar_pkg;
    typedef enum logic [1:0] {PWR_OFF, PWR_STBY, PWR_ON} pwr_state_t;
    typedef enum logic [1:0] {XF_IDLE, XF_ACQ, XF_CONV} xfer_state_t;
    typedef struct packed {
        logic ref_disable;
        logic channel_count_select;
        logic channel;
        logic power_mode_high_bit;
        logic power_mode_low_bit;
    } ctrl_t;
    typedef struct packed {
        logic channel;
        logic [`SAR_BITS-1:0] code;
    } result_t;
endpackage

// *** sar_adc_ctrl.sv ***
// result fifo and converter control with power-state machine
`timescale 1ns/1ps
`include "sar_consts.svh"

module result_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // clock
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = ce && in_valid && in_ready;
    wire pop = ce && out_valid && out_ready;

    assign in_ready = cnt_q != (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data = mem[rd_q];

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_q] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= AW'((wr_q + 1'b1) % DEPTH);
            if (pop)
                rd_q <= AW'((rd_q + 1'b1) % DEPTH);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// Function
// - code is straight binary, one step per reference over 4096
// - serial word is four zeros then 12-bit result, msb first
// - reference bit clear enables internal 2.5 V reference, set disables it
// - dual-channel mode takes reference from supply rail
// - power bits: 00 select-shutdown, 01 on, 10 auto-off, 11 auto-standby
// - auto modes power down on 16th rising clock after select falls
// - auto modes wake on first falling clock after select falls
// - mode 00 sleeps on select rise, wakes on select fall
// - mode 00 abandons a running conversion when select rises
// - power-on state is mode 00 with both power bits zero
// - auto-standby wakes fast enough to convert in the same transfer
// - data input held low loads all zeros each transfer
// - successive approximation decides one bit per rising clock, twelve steps in all
// - first eight clock bits of a transfer load the control register
// - sample and conversion start on second rising clock edge
module sar_adc_ctrl #(
    parameter int DEPTH = `FIFO_DEPTH
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // serial pins from the host
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    // analog core
    input wire logic comp_in,
    output logic [`SAR_BITS-1:0] dac_code,
    output logic hold,
    output logic core_on,
    output logic core_ready,
    output logic ref_on,
    output logic ref_from_supply,
    output logic chan_sel,
    // result stream
    output logic res_valid,
    input wire logic res_ready,
    output sar_pkg::result_t res_data
);
    ////////////////////////////////////////////////////////////////////////
    function automatic sar_pkg::ctrl_t to_ctrl(input logic [7:0] sr);
        sar_pkg::ctrl_t c;
        c.ref_disable = sr[`CTRL_REF_POS];
        c.channel_count_select = sr[`CTRL_DUAL_POS];
        c.channel = sr[`CTRL_CH_POS];
        c.power_mode_high_bit = sr[`CTRL_PMH_POS];
        c.power_mode_low_bit = sr[`CTRL_PML_POS];
        return c;
    endfunction

    function automatic logic [`SAR_BITS-1:0] sar_step(
        input logic [`SAR_BITS-1:0] code, input logic [3:0] pos,
        input logic keep);
        logic [`SAR_BITS-1:0] r;
        r = code;
        r[pos] = keep;
        if (pos != 4'h0)
            r[pos - 4'h1] = 1'b1;
        return r;
    endfunction

    function automatic sar_pkg::pwr_state_t next_pwr(
        input logic [1:0] m, input sar_pkg::pwr_state_t p,
        input logic fall, input logic rise, input logic down,
        input logic wake);
        sar_pkg::pwr_state_t n;
        n = p;
        unique case (m)
            `PM_CS_SHUTDOWN:
                n = rise ? sar_pkg::PWR_OFF : fall ? sar_pkg::PWR_ON : p;
            `PM_ALWAYS_ON:
                n = sar_pkg::PWR_ON;
            `PM_AUTO_SHUTDOWN:
                n = down ? sar_pkg::PWR_OFF : wake ? sar_pkg::PWR_ON : p;
            `PM_AUTO_STANDBY:
                n = down ? sar_pkg::PWR_STBY : wake ? sar_pkg::PWR_ON : p;
        endcase
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pins cross into clk through two flops each
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic sclk_prev_q;
    logic cs_prev_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= 4'h1;
            sync_q <= 4'h1;
            sclk_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end
        else if (ce)
        begin
            meta_q <= {comp_in, din, sclk, cs_n};
            sync_q <= meta_q;
            sclk_prev_q <= sync_q[1];
            cs_prev_q <= sync_q[0];
        end
    end

    wire cs_s = sync_q[0];
    wire sclk_s = sync_q[1];
    wire din_s = sync_q[2];
    wire comp_s = sync_q[3];
    wire act = !cs_s;
    wire cs_fall = cs_prev_q && !cs_s;
    wire cs_rise = !cs_prev_q && cs_s;
    // select high gates the serial clock
    wire sclk_rise = act && sclk_s && !sclk_prev_q;
    wire sclk_fall = act && !sclk_s && sclk_prev_q;

    ////////////////////////////////////////////////////////////////////////
    logic [4:0] rise_cnt_q;
    logic [4:0] fall_cnt_q;
    logic [7:0] ctrl_sr_q;
    sar_pkg::ctrl_t ctrl_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rise_cnt_q <= 5'h00;
            fall_cnt_q <= 5'h00;
        end
        else if (ce)
        begin
            if (cs_fall)
                rise_cnt_q <= 5'h00;
            else if (sclk_rise && rise_cnt_q < 5'(`PDOWN_EDGE))
                rise_cnt_q <= rise_cnt_q + 5'h01;
            if (cs_fall)
                fall_cnt_q <= 5'h00;
            else if (sclk_fall && fall_cnt_q < 5'(`PDOWN_EDGE))
                fall_cnt_q <= fall_cnt_q + 5'h01;
        end
    end

    wire shift_in = sclk_rise && rise_cnt_q < 5'(`CTRL_BITS);
    // load only at select rise, once a full control byte is in
    wire ctrl_load = cs_rise && rise_cnt_q >= 5'(`CTRL_BITS);
    wire sar_pkg::ctrl_t ctrl_d = ctrl_load ? to_ctrl(ctrl_sr_q) : ctrl_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_sr_q <= `CTRL_RST;
            ctrl_q <= to_ctrl(`CTRL_RST);
        end
        else if (ce)
        begin
            if (shift_in)
                ctrl_sr_q <= {ctrl_sr_q[6:0], din_s};
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sar_pkg::pwr_state_t pwr_q;
    logic [10:0] wake_cnt_q;
    wire [1:0] mode_d = {ctrl_d.power_mode_high_bit, ctrl_d.power_mode_low_bit};
    wire auto_mode = ctrl_q.power_mode_high_bit;
    // down on the 16th rising edge
    wire auto_down = auto_mode && sclk_rise
        && rise_cnt_q == 5'(`PDOWN_EDGE - 1);
    wire auto_wake = auto_mode && sclk_fall && fall_cnt_q == 5'h00;
    // auto mode loaded after a full frame sleeps at once
    wire load_down = ctrl_load && rise_cnt_q == 5'(`PDOWN_EDGE);
    wire sar_pkg::pwr_state_t pwr_d = next_pwr(mode_d, pwr_q, cs_fall,
        cs_rise, auto_down || load_down, auto_wake);
    wire waking = pwr_d == sar_pkg::PWR_ON && pwr_q != sar_pkg::PWR_ON;
    // standby keeps the reference, so its wake is short
    wire [10:0] wake_len = (pwr_q == sar_pkg::PWR_STBY)
        ? 11'(`WAKE_STBY_CYC - 1) : 11'(`WAKE_FULL_CYC - 1);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pwr_q <= sar_pkg::PWR_OFF;
            wake_cnt_q <= 11'h000;
            core_on <= 1'b0;
            core_ready <= 1'b0;
            ref_on <= 1'b0;
            ref_from_supply <= 1'b0;
            chan_sel <= 1'b0;
        end
        else if (ce)
        begin
            pwr_q <= pwr_d;
            wake_cnt_q <= waking ? wake_len
                : (wake_cnt_q != 11'h000 ? wake_cnt_q - 11'h001 : 11'h000);
            core_on <= pwr_d == sar_pkg::PWR_ON;
            core_ready <= pwr_q == sar_pkg::PWR_ON && !waking
                && wake_cnt_q == 11'h000;
            ref_on <= !ctrl_d.ref_disable && pwr_d != sar_pkg::PWR_OFF;
            ref_from_supply <= ctrl_d.channel_count_select;
            chan_sel <= ctrl_d.channel_count_select && ctrl_d.channel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // a conversion only starts when its result is sure to fit the fifo
    sar_pkg::xfer_state_t xfer_q;
    sar_pkg::xfer_state_t xfer_d;
    logic conv_ok_q;
    logic fifo_in_ready;
    wire start = xfer_q == sar_pkg::XF_ACQ && sclk_rise
        && rise_cnt_q == 5'(`SAMPLE_EDGE - 1)
        && pwr_q == sar_pkg::PWR_ON && fifo_in_ready;
    wire step = xfer_q == sar_pkg::XF_CONV && sclk_rise && !cs_rise;
    wire last = step && rise_cnt_q == 5'(`LAST_DECIDE_EDGE - 1);
    wire [3:0] trial_pos = 4'(5'(`LAST_DECIDE_EDGE - 1) - rise_cnt_q);
    wire [`SAR_BITS-1:0] stepped = sar_step(dac_code, trial_pos, comp_s);
    wire sar_pkg::result_t push_data = '{channel: chan_sel, code: stepped};

    always_comb
    begin
        xfer_d = xfer_q;
        unique case (xfer_q)
            sar_pkg::XF_IDLE:
                if (cs_fall)
                    xfer_d = sar_pkg::XF_ACQ;
            sar_pkg::XF_ACQ:
                if (start)
                    xfer_d = sar_pkg::XF_CONV;
                else if (sclk_rise && rise_cnt_q >= 5'(`SAMPLE_EDGE - 1))
                    xfer_d = sar_pkg::XF_IDLE;
            sar_pkg::XF_CONV:
                if (last)
                    xfer_d = sar_pkg::XF_IDLE;
        endcase
        if (cs_rise)
            xfer_d = sar_pkg::XF_IDLE;
    end

    wire [4:0] next_fall = fall_cnt_q + 5'h01;
    wire lead = next_fall < 5'(`LEAD_ZEROS) || next_fall >= 5'(`WORD_BITS);
    wire [3:0] out_pos = 4'(5'(`WORD_BITS - 1) - next_fall);
    // zeros first, then decided bits msb first
    wire out_bit = conv_ok_q && !lead && dac_code[out_pos];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            xfer_q <= sar_pkg::XF_IDLE;
            dac_code <= 12'h000;
            hold <= 1'b0;
            conv_ok_q <= 1'b0;
            dout <= 1'b0;
            dout_oe <= 1'b0;
        end
        else if (ce)
        begin
            xfer_q <= xfer_d;
            if (start)
                dac_code <= `SAR_MID_CODE;
            else if (step)
                dac_code <= stepped;
            hold <= xfer_d == sar_pkg::XF_CONV;
            conv_ok_q <= start || (conv_ok_q && !cs_fall);
            if (cs_fall)
                dout <= 1'b0;
            else if (sclk_fall)
                dout <= out_bit;
            dout_oe <= act;
        end
    end

    result_fifo #(.WIDTH($bits(sar_pkg::result_t)), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .in_valid(last),
        .in_ready(fifo_in_ready),
        .in_data(push_data),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data)
    );

    ////////////////////////////////////////////////////////////////////////
    a_lead_zeros: assert property (@(posedge clk) disable iff (rst)
        dout_oe && fall_cnt_q < 5'(`LEAD_ZEROS) |-> !dout)
        else $error("leading bit not zero");
    a_ctrl_load: assert property (@(posedge clk) disable iff (rst)
        ce && ctrl_load |=> ctrl_q == to_ctrl($past(ctrl_sr_q)))
        else $error("control byte not loaded");
    a_cs_shutdown: assert property (@(posedge clk) disable iff (rst)
        ce && cs_rise && mode_d == `PM_CS_SHUTDOWN
        |=> pwr_q == sar_pkg::PWR_OFF ##1 !core_on)
        else $error("no shutdown on select rise");
    a_auto_down: assert property (@(posedge clk) disable iff (rst)
        ce && auto_down && !cs_rise |=> pwr_q != sar_pkg::PWR_ON)
        else $error("auto mode stayed up");
    a_auto_wake: assert property (@(posedge clk) disable iff (rst)
        ce && auto_wake && !cs_rise |=> pwr_q == sar_pkg::PWR_ON)
        else $error("auto mode did not wake");
    a_sample_edge: assert property (@(posedge clk) disable iff (rst)
        ce && start |=> hold && dac_code == `SAR_MID_CODE)
        else $error("conversion not started at sample edge");
    a_reset_mode: assert property (@(posedge clk)
        rst |=> ctrl_q == to_ctrl(`CTRL_RST) && pwr_q == sar_pkg::PWR_OFF)
        else $error("reset mode not zero");
    a_ref_off: assert property (@(posedge clk) disable iff (rst)
        ce && ctrl_q.ref_disable && !ctrl_load |=> !ref_on)
        else $error("reference on while disabled");
    a_dual_ref: assert property (@(posedge clk) disable iff (rst)
        ce && ctrl_q.channel_count_select && !ctrl_load |=> ref_from_supply)
        else $error("dual mode not on supply reference");
    a_abandon: assert property (@(posedge clk) disable iff (rst)
        ce && cs_rise && xfer_q == sar_pkg::XF_CONV |=> !hold && !$rose(res_valid))
        else $error("conversion not abandoned");
    a_push_time: assert property (@(posedge clk) disable iff (rst)
        ce && last |=> !hold && res_valid)
        else $error("result not pushed at last decision");

    c_full_conv: cover property (@(posedge clk) disable iff (rst) last);
    c_fifo_full: cover property (@(posedge clk) disable iff (rst) !fifo_in_ready);
    c_stby_wake: cover property (@(posedge clk) disable iff (rst)
        pwr_q == sar_pkg::PWR_STBY ##1 pwr_q == sar_pkg::PWR_ON);
endmodule

// *** sar_host_model.sv ***
// serial host model driving select, serial clock and data in
`timescale 1ns/1ps

module sar_host_model #(
    parameter int HALF = 6
) (
    // clock
    input wire logic clk,
    // serial pins
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout
);
    logic [7:0] ctrl_q;
    logic [15:0] word_q;
    int n_q;

    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b1;
        n_q = 0;
    end

    // select falls, then lead cycles of wake allowance
    task automatic start(input logic [7:0] ctrl, input int lead);
        @(negedge clk);
        ctrl_q = ctrl;
        word_q = 16'h0000;
        n_q = 0;
        cs_n = 1'b0;
        repeat (lead) @(negedge clk);
    endtask

    // clock idles low; dout is taken just before each rise
    task automatic cycles(input int k);
        repeat (k)
        begin
            // control byte msb first, then a toggling line
            din = (n_q < 8) ? ctrl_q[7 - n_q] : ~din;
            repeat (HALF) @(negedge clk);
            word_q = {word_q[14:0], dout};
            sclk = 1'b1;
            n_q = n_q + 1;
            repeat (HALF) @(negedge clk);
            sclk = 1'b0;
        end
    endtask

    // released data line shows the inverse of its last level
    task automatic stop();
        repeat (HALF) @(negedge clk);
        cs_n = 1'b1;
        din = ~din;
        repeat (2 * HALF) @(negedge clk);
    endtask
endmodule

// *** tb_sar_adc_power_and_output_control.sv ***
// testbench for the converter power and output control
`timescale 1ns/1ps

module tb_sar_adc_power_and_output_control;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [11:0] vin;
        logic on;
        logic refon;
        logic sup;
    } row_t;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic res_ready = 1'b0;
    logic [11:0] vin = 12'h000;
    logic cs_n, sclk, din, dout, dout_oe, comp_in, hold, core_on;
    logic core_ready, ref_on, ref_from_supply, chan_sel, res_valid;
    logic [11:0] dac_code;
    sar_pkg::result_t res_data;
    logic [7:0] prev;
    int miscompares = 0;
    int cmp_count = 0;
    int tick_q = 0;
    row_t rows [6];

    always #2 clk = ~clk;
    // ideal comparator: high while the input is at or above the trial
    assign comp_in = (vin >= dac_code);

    sar_adc_ctrl #(.DEPTH(16)) DUT (.clk(clk), .rst(rst), .ce(ce),
        .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
        .dout_oe(dout_oe), .comp_in(comp_in), .dac_code(dac_code),
        .hold(hold), .core_on(core_on), .core_ready(core_ready),
        .ref_on(ref_on), .ref_from_supply(ref_from_supply),
        .chan_sel(chan_sel), .res_valid(res_valid),
        .res_ready(res_ready), .res_data(res_data));

    sar_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din),
        .dout(dout));

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (cmp_count > 0 && miscompares == 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic xfer(input logic [7:0] c, input int lead);
        host.start(c, lead);
        host.cycles(16);
        host.stop();
    endtask

    task automatic pop(input logic [12:0] exp);
        check("result", {3'h0, exp}, {3'h0, res_data});
        @(negedge clk);
        res_ready = 1'b1;
        @(negedge clk);
        res_ready = 1'b0;
        @(negedge clk);
    endtask

    // hang guard, well above the expected run length
    always @(posedge clk)
    begin
        tick_q <= tick_q + 1;
        if (tick_q == 40000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    initial
    begin
        rows[0] = {8'h01, 12'h000, 1'b1, 1'b1, 1'b0};
        rows[1] = {8'h21, 12'hFFF, 1'b1, 1'b0, 1'b0};
        // dual channel with the internal reference switched off
        rows[2] = {8'h39, 12'h800, 1'b1, 1'b0, 1'b1};
        rows[3] = {8'h03, 12'h7FF, 1'b0, 1'b1, 1'b0};
        rows[4] = {8'h02, 12'h001, 1'b0, 1'b0, 1'b0};
        // data line low for the whole control byte
        rows[5] = {8'h00, 12'hABC, 1'b0, 1'b0, 1'b0};
        prev = 8'h00;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        wait_clk(2);
        check("oe", 16'h0, {15'h0, dout_oe});
        check("on", 16'h0, {15'h0, core_on});
        check("valid", 16'h0, {15'h0, res_valid});
        for (int r = 0; r < 6; r++)
        begin
            vin = rows[r].vin;
            // lead covers the full wake allowance when select fall wakes the core; auto modes wake after it, on the first fall
            xfer(rows[r].ctrl, 1260);
            check("word", {4'h0, vin}, host.word_q);
            check("on", {15'h0, rows[r].on}, {15'h0, core_on});
            check("ref", {15'h0, rows[r].refon}, {15'h0, ref_on});
            check("sup", {15'h0, rows[r].sup},
                {15'h0, ref_from_supply});
            check("chan", {15'h0, rows[r].ctrl[4] & rows[r].ctrl[3]},
                {15'h0, chan_sel});
            pop({prev[4] & prev[3], vin});
            prev = rows[r].ctrl;
        end
        check("valid", 16'h0, {15'h0, res_valid});
        // select rise mid conversion in select-controlled mode
        host.start(8'h00, 8);
        check("on", 16'h1, {15'h0, core_on});
        check("ready", 16'h0, {15'h0, core_ready});
        check("oe", 16'h1, {15'h0, dout_oe});
        host.cycles(1);
        check("hold", 16'h0, {15'h0, hold});
        host.cycles(1);
        check("hold", 16'h1, {15'h0, hold});
        host.cycles(4);
        host.stop();
        check("on", 16'h0, {15'h0, core_on});
        check("hold", 16'h0, {15'h0, hold});
        check("valid", 16'h0, {15'h0, res_valid});
        check("oe", 16'h0, {15'h0, dout_oe});
        host.start(8'h01, 1300);
        check("ready", 16'h1, {15'h0, core_ready});
        host.cycles(16);
        host.stop();
        pop({1'b0, vin});
        xfer(8'h03, 8);
        pop({1'b0, vin});
        // standby mode: wake on first fall, sleep on rise 16
        host.start(8'h03, 8);
        check("on", 16'h0, {15'h0, core_on});
        check("ref", 16'h1, {15'h0, ref_on});
        host.cycles(1);
        wait_clk(6);
        check("on", 16'h1, {15'h0, core_on});
        check("ready", 16'h0, {15'h0, core_ready});
        host.cycles(14);
        check("on", 16'h1, {15'h0, core_on});
        host.cycles(1);
        wait_clk(2);
        check("on", 16'h0, {15'h0, core_on});
        check("word", {4'h0, vin}, host.word_q);
        host.stop();
        pop({1'b0, vin});
        // wake from standby, then wait out the short allowance
        host.start(8'h01, 8);
        host.cycles(1);
        wait_clk(260);
        check("ready", 16'h1, {15'h0, core_ready});
        host.cycles(15);
        host.stop();
        pop({1'b0, vin});
        // a byte cut short leaves the mode alone
        host.start(8'h02, 8);
        host.cycles(5);
        host.stop();
        check("on", 16'h1, {15'h0, core_on});
        // fill the result buffer while the consumer stalls
        for (int i = 0; i < 17; i++)
        begin
            vin = 12'(i * 273);
            xfer(8'h01, 8);
        end
        check("word", 16'h0000, host.word_q);
        for (int i = 0; i < 16; i++)
            pop({1'b0, 12'(i * 273)});
        check("valid", 16'h0, {15'h0, res_valid});
        // clock enable low freezes the select path
        ce = 1'b0;
        host.start(8'h01, 10);
        check("oe", 16'h0, {15'h0, dout_oe});
        ce = 1'b1;
        wait_clk(4);
        check("oe", 16'h1, {15'h0, dout_oe});
        host.cycles(16);
        host.stop();
        check("word", {4'h0, vin}, host.word_q);
        pop({1'b0, vin});
        // reset in mid-run drops the buffered result and the mode
        xfer(8'h01, 8);
        rst = 1'b1;
        wait_clk(3);
        rst = 1'b0;
        wait_clk(2);
        check("valid", 16'h0, {15'h0, res_valid});
        check("on", 16'h0, {15'h0, core_on});
        xfer(8'h00, 1260);
        check("on", 16'h0, {15'h0, core_on});
        pop({1'b0, vin});
        print_verdict();
    end
endmodule
